// ==== hdl/far_add_unit.sv ====
// 8-bit adder with carry in and the arithmetic flags
// assumes subtraction is fed as a + ~b + carry by the caller
`timescale 1ns/1ps
`default_nettype none

module far_add_unit (
  // operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  // result and flags
  output logic      [7:0] sum,
  output logic            carry,
  output logic            half,
  output logic            ovf,
  output logic            sgn
);

  logic [8:0] full;
  logic [4:0] low;

  // nine and five bit sums give carry and half carry directly
  assign full  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign low   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign sum   = full[7:0];
  assign carry = full[8];
  assign half  = low[4];
  // overflow when like signs give an unlike sign
  assign ovf   = (a[7] == b[7]) && (full[7] != a[7]);
  // true sign of the result, good even past overflow
  assign sgn   = ovf ^ full[7];

endmodule : far_add_unit

`default_nettype wire

// ==== hdl/far_alu_core.sv ====
// far-memory alu: accumulator, flags and data memory behind apb
// assumes an apb3 master on pclk; one command runs in one cycle
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "far_alu_regs.svh"

// Behaviour
// RULE1: full address reaches any byte, no banks
// RULE2: add with carry, to acc or memory
// RULE3: plain add, to acc or memory
// RULE4: and, to acc or memory, zero only
// RULE5: or, to acc or memory, zero only
// RULE6: byte clear writes zero, flags kept
// RULE7: bit clear zeroes one bit only
// RULE8: complement to memory or acc, zero only
// RULE9: decimal adjust acc, result to memory
// RULE10: decimal adjust changes carry only
// RULE11: decrement to memory or acc, zero only
// RULE12: increment to memory or acc, zero only
// RULE13: move either way, flags kept
// RULE14: acc-result forms never write memory
// RULE15: rotate left, bit 7 into bit 0
// RULE16: rotate left through carry
// RULE17: rotate right, bit 0 into bit 7
// RULE18: rotate right through carry
// RULE19: subtract with borrow, six flags
// RULE20: carry clear means negative result
// RULE21: zero flag means 8-bit result zero
module far_alu_core #(
  parameter int DEPTH = 512,
  parameter int AW    = 9
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // apb state
  logic        ack_r;
  logic [31:0] prdata_r;
  logic        done;
  logic        wr_done;
  logic        addr_ok;
  // command state
  far_alu_pkg::op_t op_r;
  logic [2:0]       bit_r;
  logic [AW-1:0]    adr_r;
  logic             busy_r;
  logic             badop_r;
  // programmer state
  logic [7:0]       acc_r;
  logic [5:0]       flags_r;
  logic [AW-1:0]    win_addr_r;
  // memory ports
  logic             ram_we;
  logic [AW-1:0]    ram_waddr;
  logic [7:0]       ram_wdata;
  logic [AW-1:0]    ram_raddr;
  logic [7:0]       mem_rd;
  // execution results
  logic [7:0]       res;
  logic             wr_mem;
  logic             wr_acc;
  logic [5:0]       flags_nxt;
  logic             bad_op;
  logic [7:0]       add_b;
  logic             add_cin;
  logic [7:0]       add_sum;
  logic             add_c;
  logic             add_h;
  logic             add_v;
  logic             add_s;
  logic             is_sub;
  logic             plain_add;
  logic             daa_lo;
  logic             daa_hi;
  logic [8:0]       daa_sum;

  // a transfer ends on the edge where pready is seen high
  assign done    = psel && penable && ack_r;
  assign wr_done = done && pwrite && addr_ok;
  assign pready  = ack_r;
  assign prdata  = prdata_r;
  // unmapped or unaligned words answer with an error
  assign pslverr = ack_r && !addr_ok;

  // decode of the five register words
  always_comb begin
    unique case (paddr)
      `FA_CMD_OFS, `FA_ACC_OFS, `FA_FLAGS_OFS,
      `FA_WIN_ADDR_OFS, `FA_WIN_DATA_OFS: addr_ok = 1'b1;
      default:                            addr_ok = 1'b0;
    endcase
  end

  // one wait cycle per access; held off while a command runs so a
  // read never sees half-updated state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
    end else if (ack_r) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= psel && penable && !busy_r;
    end
  end

  // read data captured in the wait cycle, stable through pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && penable && !ack_r && !busy_r && !pwrite) begin
      prdata_r <= 32'h0000_0000;
      unique case (paddr)
        `FA_CMD_OFS: begin
          prdata_r[`FA_CMD_OP_MSB:`FA_CMD_OP_LSB]   <= op_r;
          prdata_r[`FA_CMD_BIT_MSB:`FA_CMD_BIT_LSB] <= bit_r;
          prdata_r[`FA_CMD_ADR_LSB +: AW]           <= adr_r;
        end
        `FA_ACC_OFS:      prdata_r[7:0]  <= acc_r;
        `FA_FLAGS_OFS: begin
          prdata_r[5:0]            <= flags_r;
          prdata_r[`FA_FLG_BUSY]   <= busy_r;
          prdata_r[`FA_FLG_BADOP]  <= badop_r;
        end
        `FA_WIN_ADDR_OFS: prdata_r[AW-1:0] <= win_addr_r;
        `FA_WIN_DATA_OFS: prdata_r[7:0]  <= mem_rd;
        default:          prdata_r       <= 32'h0000_0000;
      endcase
    end
  end

  // command capture; the run takes exactly the next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r   <= far_alu_pkg::far_move_to_acc;
      bit_r  <= 3'h0;
      adr_r  <= `FA_ADR_RST;
      busy_r <= 1'b0;
    end else if (wr_done && paddr == `FA_CMD_OFS) begin
      op_r   <= far_alu_pkg::op_t'(pwdata[`FA_CMD_OP_MSB:`FA_CMD_OP_LSB]);
      bit_r  <= pwdata[`FA_CMD_BIT_MSB:`FA_CMD_BIT_LSB];
      adr_r  <= pwdata[`FA_CMD_ADR_LSB +: AW];
      busy_r <= 1'b1;
    end else begin
      busy_r <= 1'b0;
    end
  end

  // last command code outside the table is remembered until the next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      badop_r <= 1'b0;
    end else if (busy_r) begin
      badop_r <= bad_op;
    end
  end

  // window address for software access to the data memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_addr_r <= `FA_ADR_RST;
    end else if (wr_done && paddr == `FA_WIN_ADDR_OFS) begin
      win_addr_r <= pwdata[AW-1:0];
    end
  end

  // RULE1 one flat address, no bank select
  assign ram_raddr = busy_r ? adr_r : win_addr_r;

  // RULE14 memory written only by mem-result forms or the window
  always_comb begin
    ram_we    = 1'b0;
    ram_waddr = win_addr_r;
    ram_wdata = pwdata[7:0];
    if (busy_r) begin
      ram_we    = wr_mem;
      ram_waddr = adr_r;
      ram_wdata = res;
    end else if (wr_done && paddr == `FA_WIN_DATA_OFS) begin
      ram_we    = 1'b1;
    end
  end

  far_data_ram #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_ram (
    .clk     (pclk),
    .wr_en   (ram_we),
    .wr_addr (ram_waddr),
    .wr_data (ram_wdata),
    .rd_addr (ram_raddr),
    .rd_data (mem_rd)
  );

  // RULE19 borrow form: acc + ~m + c, so c=1 means no borrow
  assign is_sub    = (op_r == far_alu_pkg::far_subtract_borrow) ||
                     (op_r == far_alu_pkg::far_subtract_borrow_to_mem);
  // RULE3 plain add has no carry in
  assign plain_add = (op_r == far_alu_pkg::far_add) ||
                     (op_r == far_alu_pkg::far_add_to_mem);
  assign add_b     = is_sub ? ~mem_rd : mem_rd;
  assign add_cin   = plain_add ? 1'b0 : flags_r[`FA_FLG_C];

  far_add_unit u_add (
    .a     (acc_r),
    .b     (add_b),
    .cin   (add_cin),
    .sum   (add_sum),
    .carry (add_c),
    .half  (add_h),
    .ovf   (add_v),
    .sgn   (add_s)
  );

  // RULE9 six added per nibble that is over nine or flagged
  assign daa_lo  = (acc_r[3:0] > `FA_DAA_LIMIT) || flags_r[`FA_FLG_AC];
  assign daa_hi  = (acc_r[7:4] > `FA_DAA_LIMIT) || flags_r[`FA_FLG_C];
  assign daa_sum = {1'b0, acc_r} + (daa_lo ? `FA_DAA_LOW_ADJ : 9'h000)
                   + (daa_hi ? `FA_DAA_HIGH_ADJ : 9'h000);

  // result, destination and flags of the running command
  always_comb begin
    res       = mem_rd;
    wr_mem    = 1'b0;
    wr_acc    = 1'b0;
    flags_nxt = flags_r;
    bad_op    = 1'b0;
    unique case (op_r)
      // RULE2 add with carry, all five arithmetic flags
      // RULE3 plain add shares the adder
      far_alu_pkg::far_add_with_carry, far_alu_pkg::far_add,
      far_alu_pkg::far_add_with_carry_to_mem, far_alu_pkg::far_add_to_mem,
      // RULE19 subtract with borrow also updates chained zero
      far_alu_pkg::far_subtract_borrow,
      far_alu_pkg::far_subtract_borrow_to_mem: begin
        res    = add_sum;
        wr_acc = (op_r == far_alu_pkg::far_add_with_carry) ||
                 (op_r == far_alu_pkg::far_add) ||
                 (op_r == far_alu_pkg::far_subtract_borrow);
        wr_mem = !wr_acc;
        // RULE20 carry out of a + ~b is the no-borrow bit
        flags_nxt[`FA_FLG_C]  = add_c;
        flags_nxt[`FA_FLG_AC] = add_h;
        flags_nxt[`FA_FLG_OV] = add_v;
        flags_nxt[`FA_FLG_SC] = add_s;
        if (is_sub) begin
          flags_nxt[`FA_FLG_CZ] = (add_sum == 8'h00) && flags_r[`FA_FLG_Z];
        end
      end
      // RULE4 bitwise and
      far_alu_pkg::far_bitwise_conj, far_alu_pkg::far_bitwise_conj_to_mem: begin
        res    = acc_r & mem_rd;
        wr_acc = (op_r == far_alu_pkg::far_bitwise_conj);
        wr_mem = !wr_acc;
      end
      // RULE5 bitwise or
      far_alu_pkg::far_bitwise_disj, far_alu_pkg::far_bitwise_disj_to_mem: begin
        res    = acc_r | mem_rd;
        wr_acc = (op_r == far_alu_pkg::far_bitwise_disj);
        wr_mem = !wr_acc;
      end
      // RULE6 byte clear
      far_alu_pkg::far_clear: begin
        res    = 8'h00;
        wr_mem = 1'b1;
      end
      // RULE7 only the chosen bit forced low
      far_alu_pkg::far_clear_bit: begin
        res        = mem_rd;
        res[bit_r] = 1'b0;
        wr_mem     = 1'b1;
      end
      // RULE8 ones complement
      far_alu_pkg::far_invert, far_alu_pkg::far_invert_to_acc: begin
        res    = ~mem_rd;
        wr_acc = (op_r == far_alu_pkg::far_invert_to_acc);
        wr_mem = !wr_acc;
      end
      // RULE10 carry set by a high adjust or a carry out
      far_alu_pkg::far_decimal_adjust: begin
        res                  = daa_sum[7:0];
        wr_mem               = 1'b1;
        flags_nxt[`FA_FLG_C] = daa_hi || daa_sum[8];
      end
      // RULE11 decrement
      far_alu_pkg::far_decrement, far_alu_pkg::far_decrement_to_acc: begin
        res    = mem_rd - 8'h01;
        wr_acc = (op_r == far_alu_pkg::far_decrement_to_acc);
        wr_mem = !wr_acc;
      end
      // RULE12 increment
      far_alu_pkg::far_increment, far_alu_pkg::far_increment_to_acc: begin
        res    = mem_rd + 8'h01;
        wr_acc = (op_r == far_alu_pkg::far_increment_to_acc);
        wr_mem = !wr_acc;
      end
      // RULE13 moves leave flags alone
      far_alu_pkg::far_move: begin
        res    = acc_r;
        wr_mem = 1'b1;
      end
      far_alu_pkg::far_move_to_acc: begin
        res    = mem_rd;
        wr_acc = 1'b1;
      end
      // RULE15 rotate left
      far_alu_pkg::far_rotate_up, far_alu_pkg::far_rotate_up_to_acc: begin
        res    = {mem_rd[6:0], mem_rd[7]};
        wr_acc = (op_r == far_alu_pkg::far_rotate_up_to_acc);
        wr_mem = !wr_acc;
      end
      // RULE16 rotate left through carry
      far_alu_pkg::far_rotate_up_thru_carry,
      far_alu_pkg::far_rotate_up_thru_carry_acc: begin
        res                  = {mem_rd[6:0], flags_r[`FA_FLG_C]};
        flags_nxt[`FA_FLG_C] = mem_rd[7];
        wr_acc = (op_r == far_alu_pkg::far_rotate_up_thru_carry_acc);
        wr_mem = !wr_acc;
      end
      // RULE17 rotate right
      far_alu_pkg::far_rotate_down, far_alu_pkg::far_rotate_down_to_acc: begin
        res    = {mem_rd[0], mem_rd[7:1]};
        wr_acc = (op_r == far_alu_pkg::far_rotate_down_to_acc);
        wr_mem = !wr_acc;
      end
      // RULE18 rotate right through carry
      far_alu_pkg::far_rotate_down_thru_carry,
      far_alu_pkg::far_rotate_down_thru_carry_acc: begin
        res                  = {flags_r[`FA_FLG_C], mem_rd[7:1]};
        flags_nxt[`FA_FLG_C] = mem_rd[0];
        wr_acc = (op_r == far_alu_pkg::far_rotate_down_thru_carry_acc);
        wr_mem = !wr_acc;
      end
      // codes past the table change no acc, flags or memory, and only raise bad_op
      default: begin
        bad_op = 1'b1;
      end
    endcase
    // RULE21 zero flag tracks the 8-bit result where it is affected
    if (!bad_op && op_r != far_alu_pkg::far_clear &&
        op_r != far_alu_pkg::far_clear_bit &&
        op_r != far_alu_pkg::far_decimal_adjust &&
        op_r != far_alu_pkg::far_move &&
        op_r != far_alu_pkg::far_move_to_acc &&
        op_r != far_alu_pkg::far_rotate_up &&
        op_r != far_alu_pkg::far_rotate_up_to_acc &&
        op_r != far_alu_pkg::far_rotate_up_thru_carry &&
        op_r != far_alu_pkg::far_rotate_up_thru_carry_acc &&
        op_r != far_alu_pkg::far_rotate_down &&
        op_r != far_alu_pkg::far_rotate_down_to_acc &&
        op_r != far_alu_pkg::far_rotate_down_thru_carry &&
        op_r != far_alu_pkg::far_rotate_down_thru_carry_acc) begin
      flags_nxt[`FA_FLG_Z] = (res == 8'h00);
    end
  end

  // accumulator: command result wins, else software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= `FA_ACC_RST;
    end else if (busy_r) begin
      if (wr_acc) begin
        acc_r <= res;
      end
    end else if (wr_done && paddr == `FA_ACC_OFS) begin
      acc_r <= pwdata[7:0];
    end
  end

  // flags: software may preload them, e.g. carry before a chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= `FA_FLAGS_RST;
    end else if (busy_r) begin
      flags_r <= flags_nxt;
    end else if (wr_done && paddr == `FA_FLAGS_OFS) begin
      flags_r <= pwdata[5:0];
    end
  end

endmodule : far_alu_core

`default_nettype wire

// ==== hdl/far_alu_pkg.sv ====
// types shared by the far-memory alu files
// assumes nothing beyond a sv-2012 compiler
package far_alu_pkg;

  // command codes written into the command register
  typedef enum logic [4:0] {
    far_add_with_carry             = 5'b00000,
    far_add_with_carry_to_mem      = 5'b00001,
    far_add                        = 5'b00010,
    far_add_to_mem                 = 5'b00011,
    far_bitwise_conj               = 5'b00100,
    far_bitwise_conj_to_mem        = 5'b00101,
    far_clear                      = 5'b00110,
    far_clear_bit                  = 5'b00111,
    far_invert                     = 5'b01000,
    far_invert_to_acc              = 5'b01001,
    far_decimal_adjust             = 5'b01010,
    far_decrement                  = 5'b01011,
    far_decrement_to_acc           = 5'b01100,
    far_increment                  = 5'b01101,
    far_increment_to_acc           = 5'b01110,
    far_move                       = 5'b01111,
    far_move_to_acc                = 5'b10000,
    far_bitwise_disj               = 5'b10001,
    far_bitwise_disj_to_mem        = 5'b10010,
    far_rotate_up                  = 5'b10011,
    far_rotate_up_to_acc           = 5'b10100,
    far_rotate_up_thru_carry       = 5'b10101,
    far_rotate_up_thru_carry_acc   = 5'b10110,
    far_rotate_down                = 5'b10111,
    far_rotate_down_to_acc         = 5'b11000,
    far_rotate_down_thru_carry     = 5'b11001,
    far_rotate_down_thru_carry_acc = 5'b11010,
    far_subtract_borrow            = 5'b11011,
    far_subtract_borrow_to_mem     = 5'b11100
  } op_t;

endpackage : far_alu_pkg

// ==== hdl/far_alu_regs.svh ====
// register offsets, field positions and reset values of the far alu
// assumes apb byte addresses with one aligned 32-bit word per register
`ifndef FAR_ALU_REGS_SVH
`define FAR_ALU_REGS_SVH

// register byte offsets
`define FA_CMD_OFS       12'h000
`define FA_ACC_OFS       12'h004
`define FA_FLAGS_OFS     12'h008
`define FA_WIN_ADDR_OFS  12'h00c
`define FA_WIN_DATA_OFS  12'h010

// command word fields
`define FA_CMD_OP_LSB    0
`define FA_CMD_OP_MSB    4
`define FA_CMD_BIT_LSB   5
`define FA_CMD_BIT_MSB   7
`define FA_CMD_ADR_LSB   8

// flag register bit positions
`define FA_FLG_C         0
`define FA_FLG_AC        1
`define FA_FLG_Z         2
`define FA_FLG_OV        3
`define FA_FLG_SC        4
`define FA_FLG_CZ        5
`define FA_FLG_BUSY      8
`define FA_FLG_BADOP     9

// reset values
`define FA_ACC_RST       8'h00
`define FA_FLAGS_RST     6'h00
`define FA_ADR_RST       9'h000

// decimal adjust constants
`define FA_DAA_LIMIT     4'h9
`define FA_DAA_LOW_ADJ   9'h006
`define FA_DAA_HIGH_ADJ  9'h060

`endif

// ==== hdl/far_data_ram.sv ====
// flat byte data memory reached by one full-width address
// assumes one writer per cycle, chosen by the instantiating block
`timescale 1ns/1ps
`default_nettype none

module far_data_ram #(
  parameter int DEPTH = 512,
  parameter int AW    = 9
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // read port, combinational
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);

  logic [7:0] mem [DEPTH];

  // no reset: contents are undefined until written, like a real sram
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule : far_data_ram

`default_nettype wire

// ==== sim/far_alu_assertions.sv ====
// checker for the far alu: apb answer timing and state kept across commands
// assumes it is bound to far_alu_core and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "far_alu_regs.svh"

module far_alu_assertions (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  // op codes that leave flags or acc alone, unused codes included
  localparam logic [31:0] KEEP_FLG = 32'he19980c0;
  localparam logic [31:0] KEEP_ACC = 32'hf2acadea;
  logic       mapped;
  logic       done_w;
  logic       fk_r;
  logic       ak_r;
  logic [5:0] fv_r;
  logic [7:0] av_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // completed writes and the mapped window
  assign done_w = psel && penable && pready && pwrite;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= `FA_WIN_DATA_OFS;

  // software value stays known until a command may change it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fk_r <= 1'b0;
      ak_r <= 1'b0;
      fv_r <= 6'h00;
      av_r <= 8'h00;
    end else if (done_w) begin
      if (paddr == `FA_FLAGS_OFS) begin
        fk_r <= 1'b1;
        fv_r <= pwdata[5:0];
      end
      if (paddr == `FA_ACC_OFS) begin
        ak_r <= 1'b1;
        av_r <= pwdata[7:0];
      end
      if (paddr == `FA_CMD_OFS) begin
        fk_r <= fk_r && KEEP_FLG[pwdata[4:0]];
        ak_r <= ak_r && KEEP_ACC[pwdata[4:0]];
      end
    end
  end

  property p_rdy_access; pready |-> psel && penable; endproperty
  property p_first_wait; psel && !penable ##1 penable |-> !pready; endproperty
  property p_answer_bound; psel && !penable |-> ##[2:3] pready; endproperty
  property p_rdy_pulse; pready |=> !pready; endproperty
  property p_err_with_rdy; pslverr |-> pready; endproperty
  property p_unmapped;
    pready && !mapped |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  property p_mapped_ok; pready && mapped |-> !pslverr; endproperty
  property p_flags_kept;
    pready && !pwrite && paddr == `FA_FLAGS_OFS && fk_r |->
      prdata[5:0] == fv_r && !prdata[8];
  endproperty
  property p_acc_kept;
    pready && !pwrite && paddr == `FA_ACC_OFS && ak_r |->
      prdata[7:0] == av_r && prdata[31:8] == 24'h0;
  endproperty

  a_rdy_access: assert property (p_rdy_access) else $error("pready outside access");
  a_first_wait: assert property (p_first_wait) else $error("no wait cycle");
  a_answer_bound: assert property (p_answer_bound) else $error("answer late");
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");
  a_err_with_rdy: assert property (p_err_with_rdy) else $error("lone pslverr");
  a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped refused");
  a_flags_kept: assert property (p_flags_kept) else $error("flags moved");
  a_acc_kept: assert property (p_acc_kept) else $error("acc moved");

  c_cmd: cover property (done_w && paddr == `FA_CMD_OFS);
  c_err: cover property (pready && pslverr);
  c_flags: cover property (pready && !pwrite && paddr == `FA_FLAGS_OFS && fk_r);
endmodule : far_alu_assertions

`default_nettype wire

// ==== sim/tb_top.sv ====
// bench for far_alu_core: reset values, command table, then address reach, refusal and second reset cases
// assumes the apb slave answers within a few cycles of each access
`timescale 1ns/1ps
`default_nettype none
`include "far_alu_regs.svh"

module tb_top;
  // one row: command, operands and flags in, results expected
  typedef struct packed {
    logic [4:0] op;
    logic [8:0] ad;
    logic [2:0] bi;
    logic [7:0] a;
    logic [7:0] m;
    logic [5:0] f;
    logic [7:0] ea;
    logic [7:0] em;
    logic [5:0] ef;
  } row_t;

  // bench state
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] q;
  logic        e;
  int          mismatches = 0;
  int          checked = 0;
  row_t        rows [33] = '{
    '{5'h00,9'h000,3'h0,8'h3a,8'hc6,6'h01,8'h01,8'hc6,6'h03},
    '{5'h01,9'h1ff,3'h0,8'h7f,8'h00,6'h21,8'h7f,8'h80,6'h2a},
    '{5'h02,9'h0a5,3'h0,8'h80,8'h80,6'h01,8'h00,8'h80,6'h1d},
    '{5'h03,9'h100,3'h0,8'h08,8'h08,6'h3f,8'h08,8'h10,6'h22},
    '{5'h04,9'h0ff,3'h0,8'hf0,8'h0f,6'h3b,8'h00,8'h0f,6'h3f},
    '{5'h05,9'h155,3'h0,8'hf3,8'h35,6'h04,8'hf3,8'h31,6'h00},
    '{5'h06,9'h1aa,3'h0,8'h55,8'hab,6'h2a,8'h55,8'h00,6'h2a},
    '{5'h07,9'h033,3'h7,8'h55,8'hff,6'h15,8'h55,8'h7f,6'h15},
    '{5'h07,9'h034,3'h0,8'h55,8'h81,6'h15,8'h55,8'h80,6'h15},
    '{5'h08,9'h1fe,3'h0,8'h11,8'h5a,6'h3f,8'h11,8'ha5,6'h3b},
    '{5'h09,9'h001,3'h0,8'h11,8'hff,6'h00,8'h00,8'hff,6'h04},
    '{5'h0a,9'h080,3'h0,8'h3c,8'h00,6'h3d,8'h3c,8'ha2,6'h3d},
    '{5'h0a,9'h081,3'h0,8'ha5,8'h00,6'h06,8'ha5,8'h0b,6'h07},
    '{5'h0b,9'h0c0,3'h0,8'h77,8'h01,6'h00,8'h77,8'h00,6'h04},
    '{5'h0c,9'h0c1,3'h0,8'h77,8'h00,6'h04,8'hff,8'h00,6'h00},
    '{5'h0d,9'h0c2,3'h0,8'h77,8'hff,6'h39,8'h77,8'h00,6'h3d},
    '{5'h0e,9'h0c3,3'h0,8'h77,8'h7f,6'h04,8'h80,8'h7f,6'h00},
    '{5'h0f,9'h10f,3'h0,8'hc3,8'h00,6'h2b,8'hc3,8'hc3,6'h2b},
    '{5'h10,9'h110,3'h0,8'h99,8'h00,6'h00,8'h00,8'h00,6'h00},
    '{5'h11,9'h111,3'h0,8'h00,8'h00,6'h00,8'h00,8'h00,6'h04},
    '{5'h12,9'h112,3'h0,8'ha0,8'h05,6'h04,8'ha0,8'ha5,6'h00},
    '{5'h13,9'h120,3'h0,8'h00,8'h81,6'h01,8'h00,8'h03,6'h01},
    '{5'h14,9'h121,3'h0,8'h00,8'h40,6'h00,8'h80,8'h40,6'h00},
    '{5'h15,9'h122,3'h0,8'h00,8'h80,6'h3e,8'h00,8'h00,6'h3f},
    '{5'h16,9'h123,3'h0,8'h00,8'h01,6'h01,8'h03,8'h01,6'h00},
    '{5'h17,9'h124,3'h0,8'h00,8'h01,6'h00,8'h00,8'h80,6'h00},
    '{5'h18,9'h125,3'h0,8'h00,8'h02,6'h3f,8'h01,8'h02,6'h3f},
    '{5'h19,9'h126,3'h0,8'h00,8'h01,6'h00,8'h00,8'h00,6'h01},
    '{5'h1a,9'h127,3'h0,8'h00,8'h00,6'h01,8'h80,8'h00,6'h00},
    '{5'h1b,9'h130,3'h0,8'h10,8'h10,6'h05,8'h00,8'h10,6'h27},
    '{5'h1b,9'h131,3'h0,8'h10,8'h10,6'h00,8'hff,8'h10,6'h10},
    '{5'h1b,9'h132,3'h0,8'h05,8'h04,6'h00,8'h00,8'h04,6'h07},
    '{5'h1c,9'h133,3'h0,8'h80,8'h01,6'h01,8'h80,8'h7f,6'h19}
  };

  far_alu_core i_far_alu_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );

  task automatic chk_val(input logic [31:0] g, x, input string s);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, g, x);
    end
  endtask : chk_val

  task automatic chk_bit(input logic g, x, input string s);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected at %0t: %s got %b", $time, s, g);
    end
  endtask : chk_bit

  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk_val(n, 32'd2, "answer cycles");
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk_bit(e, 1'b0, "write error");
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input string s);
    apb(1'b0, a, 32'h0);
    chk_bit(e, 1'b0, "read error");
    chk_val(q, x, s);
  endtask : rd_chk

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // 20 mhz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // bounds a hang to far beyond the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr  = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`FA_CMD_OFS, 32'h00000010, "cmd reset");
    rd_chk(`FA_ACC_OFS, 32'h0, "acc reset");
    rd_chk(`FA_FLAGS_OFS, 32'h0, "flags reset");
    rd_chk(`FA_WIN_ADDR_OFS, 32'h0, "addr reset");
    $display("test reset values done");
    foreach (rows[i]) begin
      wr(`FA_WIN_ADDR_OFS, {23'h0, rows[i].ad});
      wr(`FA_WIN_DATA_OFS, {24'h0, rows[i].m});
      wr(`FA_ACC_OFS, {24'h0, rows[i].a});
      wr(`FA_FLAGS_OFS, {26'h0, rows[i].f});
      wr(`FA_CMD_OFS, {15'h0, rows[i].ad, rows[i].bi, rows[i].op});
      rd_chk(`FA_ACC_OFS, {24'h0, rows[i].ea}, "acc");
      rd_chk(`FA_FLAGS_OFS, {26'h0, rows[i].ef}, "flags");
      rd_chk(`FA_WIN_DATA_OFS, {24'h0, rows[i].em}, "mem");
    end
    $display("test command table done");
    // bytes a bank apart must not alias
    wr(`FA_WIN_ADDR_OFS, 32'h000);
    rd_chk(`FA_WIN_DATA_OFS, 32'hc6, "low byte");
    wr(`FA_WIN_ADDR_OFS, 32'h0ff);
    rd_chk(`FA_WIN_DATA_OFS, 32'h0f, "mid byte");
    wr(`FA_WIN_ADDR_OFS, 32'h1ff);
    rd_chk(`FA_WIN_DATA_OFS, 32'h80, "top byte");
    $display("test address reach done");
    // refused accesses and an unused op code
    apb(1'b0, 12'h014, 32'h0);
    chk_bit(e, 1'b1, "unmapped read");
    chk_val(q, 32'h0, "unmapped data");
    apb(1'b1, 12'h006, 32'hff);
    chk_bit(e, 1'b1, "unaligned write");
    wr(`FA_ACC_OFS, 32'h5a);
    wr(`FA_FLAGS_OFS, 32'h15);
    wr(`FA_CMD_OFS, 32'h0000001d);
    rd_chk(`FA_FLAGS_OFS, 32'h215, "bad op flags");
    rd_chk(`FA_ACC_OFS, 32'h5a, "bad op acc");
    wr(`FA_CMD_OFS, 32'h00000013);
    rd_chk(`FA_FLAGS_OFS, 32'h15, "bad op cleared");
    rd_chk(`FA_WIN_DATA_OFS, 32'h80, "far byte kept");
    $display("test refusals done");
    // second reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`FA_ACC_OFS, 32'h0, "acc rereset");
    rd_chk(`FA_FLAGS_OFS, 32'h0, "flags rereset");
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : tb_top

bind far_alu_core far_alu_assertions i_far_alu_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr)
);

`default_nettype wire
